// ---- rtl/timebase_divider.sv ----
`timescale 1ns/1ps
`include "watch_timer_defs.svh"

module timebase_divider #(
   parameter int LOG2 = `WT_MAIN_DIV_LOG2
) (
   input  wire logic clock,
   input  wire logic reset_n,
   output logic      tick
);

   logic [LOG2-1:0] count;

   initial begin
      if (LOG2 < 1) begin
         $error("divider needs at least one stage");
      end
   end

   // free running so the main timebase phase never depends on the mode
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         count <= '0;
      end else begin
         count <= count + 1'b1;
      end
   end

   assign tick = (count == {LOG2{1'b1}});

endmodule : timebase_divider

// ---- rtl/watch_and_interval_timer.sv ----
// Function
// RULE_01 - select bit picks main/128 or subsystem timebase
// RULE_02 - interval tick every 2^4..2^11 timebase cycles
// RULE_03 - watch period 2^14, 2^13, 2^5, 2^4
// RULE_04 - run bit low stops and clears counter
// RULE_05 - enable low clears prescaler and counter
// RULE_06 - watch counts only with enable and run
// RULE_07 - run low alone keeps prescaler running
// RULE_08 - interval follows enable bit only
// RULE_09 - first watch tick late by at most 2^9; code never makes it late, but up to 2^9 - 1 early instead
// RULE_10 - mode resets zero, bit and byte writes
// RULE_11 - software keeps select and tap fixed while running
// RULE_12 - watch and interval run together
// RULE_13 - counter steps on 2^9 tap or timebase
`timescale 1ns/1ps
`include "watch_timer_defs.svh"

module watch_and_interval_timer #(
   parameter int PRESC_WIDTH = `WT_PRESC_WIDTH,
   parameter int COUNT_WIDTH = `WT_COUNT_WIDTH
) (
   input  wire logic                      clock,
   input  wire logic                      reset_n,
   input  wire logic                      sub_osc_clk,
   input  wire watch_timer_pkg::reg_req_s reg_req,
   output logic [7:0]                     reg_rdata,
   output logic                           watch_tick_irq,
   output logic                           interval_tick_irq
);

   // =======================================================================
   // elaboration checks
   // =======================================================================
   initial begin
      if (PRESC_WIDTH < `WT_INTERVAL_LOG2 + 8 - 1) begin
         $error("prescaler too narrow for the widest interval tap");
      end
      if (PRESC_WIDTH <= `WT_FWX_LOG2) begin
         $error("prescaler too narrow for the watch counter tap");
      end
      if (COUNT_WIDTH < 2) begin
         $error("watch counter too narrow");
      end
   end

   // =======================================================================
   // declarations
   // =======================================================================
   watch_timer_pkg::mode_s   mode;
   logic [7:0]               mode_bits;
   logic [7:0]               next_mode_bits;
   logic                     addr_hit;
   logic                     main_tick;
   logic                     sub_prev;
   logic                     sub_edge;
   logic                     tb_tick;
   logic [PRESC_WIDTH-1:0]   presc;
   logic [PRESC_WIDTH-1:0]   interval_mask;
   logic                     interval_fire;
   logic                     fwx_fire;
   logic                     long_period;
   logic                     half_span;
   logic                     watch_step;
   logic                     watch_run;
   logic [COUNT_WIDTH-1:0]   watch_count;
   logic                     watch_fire;

   assign mode_bits = mode;
   assign addr_hit  = (reg_req.addr == `WT_MODE_ADDR);

   // =======================================================================
   // mode register
   // =======================================================================
   // RULE_10 bit and byte writes
   always_comb begin
      next_mode_bits = mode_bits;
      if (addr_hit && reg_req.wr_byte) begin
         next_mode_bits = reg_req.wdata;
      end else if (addr_hit && reg_req.wr_bit) begin
         next_mode_bits[reg_req.bit_sel] = reg_req.bit_val;
      end
   end

   // RULE_10 reset to zero
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         mode <= watch_timer_pkg::mode_s'(`WT_MODE_RESET);
      end else begin
         mode <= watch_timer_pkg::mode_s'(next_mode_bits);
      end
   end

   // reads return zero off the decoded address
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_req.rd && addr_hit) begin
         reg_rdata <= mode_bits;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // =======================================================================
   // timebase
   // =======================================================================
   timebase_divider #(
      .LOG2 (`WT_MAIN_DIV_LOG2)
   ) main_div (
      .clock   (clock),
      .reset_n (reset_n),
      .tick    (main_tick)
   );

   // subsystem oscillator arrives synchronous; one rising edge is one cycle
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         sub_prev <= 1'b0;
      end else begin
         sub_prev <= sub_osc_clk;
      end
   end

   assign sub_edge = sub_osc_clk && !sub_prev;

   // RULE_01 timebase select
   assign tb_tick = mode.timebase_select ? sub_edge : main_tick;

   // =======================================================================
   // prescaler, shared by both functions
   // =======================================================================
   // RULE_05 enable clears prescaler
   // RULE_08 interval follows enable
   always_ff @(posedge clock) begin
      if (!reset_n || !mode.global_enable) begin
         presc <= '0;
      end else if (tb_tick) begin
         presc <= presc + 1'b1;
      end
   end

   // RULE_02 tap selects interval
   assign interval_mask = ~({PRESC_WIDTH{1'b1}} << (`WT_INTERVAL_LOG2 + int'(mode.interval_tap)));
   assign interval_fire = mode.global_enable && tb_tick && ((presc & interval_mask) == interval_mask);

   // RULE_13 counter source tap
   assign fwx_fire = tb_tick && (presc[`WT_FWX_LOG2-1:0] == {`WT_FWX_LOG2{1'b1}});

   // =======================================================================
   // watch counter
   // =======================================================================
   // RULE_03 period decode
   always_comb begin
      long_period = 1'b1;
      half_span   = 1'b0;
      case (mode.tick_period)
         watch_timer_pkg::PERIOD_2P14: begin
            long_period = 1'b1;
            half_span   = 1'b0;
         end
         watch_timer_pkg::PERIOD_2P13: begin
            long_period = 1'b1;
            half_span   = 1'b1;
         end
         watch_timer_pkg::PERIOD_2P5: begin
            long_period = 1'b0;
            half_span   = 1'b0;
         end
         watch_timer_pkg::PERIOD_2P4: begin
            long_period = 1'b0;
            half_span   = 1'b1;
         end
         default: begin
            long_period = 1'b1;
            half_span   = 1'b0;
         end
      endcase
   end

   // RULE_13 step source
   assign watch_step = long_period ? fwx_fire : tb_tick;

   // RULE_06 enable and run
   // RULE_07 run low leaves prescaler alone, so first tick may come early
   assign watch_run = mode.global_enable && mode.counter_run;

   // RULE_04 run bit clears counter
   watch_counter #(
      .WIDTH (COUNT_WIDTH)
   ) counter (
      .clock     (clock),
      .reset_n   (reset_n),
      .clear     (!watch_run),
      .step      (watch_step),
      .half_span (half_span),
      .count     (watch_count),
      .overflow  (watch_fire)
   );

   // =======================================================================
   // tick outputs
   // =======================================================================
   // RULE_12 both ticks from one timebase; the watch uses the prescaler only for the 2^14 and 2^13 periods
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         watch_tick_irq <= 1'b0;
      end else begin
         watch_tick_irq <= watch_fire;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         interval_tick_irq <= 1'b0;
      end else begin
         interval_tick_irq <= interval_fire;
      end
   end

   // =======================================================================
   // checks
   // =======================================================================
   logic [7:0] main_gap;
   logic       main_seen;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         main_gap  <= 8'h00;
         main_seen <= 1'b0;
      end else if (main_tick) begin
         main_gap  <= 8'h00;
         main_seen <= 1'b1;
      end else begin
         main_gap <= main_gap + 8'h01;
      end
   end

   chk_mode_reset: assert property ( // RULE_10
      @(posedge clock) !reset_n |=> (mode_bits == 8'h00 && reg_rdata == 8'h00))
      else $error("mode register not zero after reset");

   chk_bit_write: assert property ( // RULE_10
      @(posedge clock) disable iff (!reset_n)
      (addr_hit && reg_req.wr_bit && !reg_req.wr_byte)
      |=> mode_bits[$past(reg_req.bit_sel)] == $past(reg_req.bit_val))
      else $error("bit write did not land");

   chk_main_rate: assert property ( // RULE_01
      @(posedge clock) disable iff (!reset_n)
      (main_tick && main_seen) |-> (main_gap == 8'((1 << `WT_MAIN_DIV_LOG2) - 1)))
      else $error("main timebase not every 128 cycles");

   chk_timebase_sub: assert property ( // RULE_01
      @(posedge clock) disable iff (!reset_n)
      (mode.timebase_select && tb_tick) |-> (sub_osc_clk && !sub_prev))
      else $error("subsystem timebase tick without rising edge");

   chk_presc_clear: assert property ( // RULE_05
      @(posedge clock) disable iff (!reset_n)
      !mode.global_enable |=> (presc == '0 && watch_count == '0))
      else $error("disable did not clear prescaler and counter");

   chk_interval_stop: assert property ( // RULE_08
      @(posedge clock) disable iff (!reset_n)
      !mode.global_enable |=> !interval_tick_irq)
      else $error("interval tick while disabled");

   chk_interval_tap: assert property ( // RULE_02
      @(posedge clock) disable iff (!reset_n)
      interval_tick_irq |-> ($past(tb_tick) && (($past(presc) & $past(interval_mask)) == $past(interval_mask))))
      else $error("interval tick off its tap");

   chk_watch_halt: assert property ( // RULE_06
      @(posedge clock) disable iff (!reset_n)
      !watch_run |=> (watch_count == '0 && !watch_tick_irq))
      else $error("watch counter moved while halted");

   chk_run_keeps_presc: assert property ( // RULE_07
      @(posedge clock) disable iff (!reset_n)
      (mode.global_enable && !mode.counter_run && tb_tick) ##1 mode.global_enable
      |-> presc == $past(presc) + 1'b1)
      else $error("prescaler stalled by run bit");

   chk_watch_source: assert property ( // RULE_13
      @(posedge clock) disable iff (!reset_n)
      (watch_tick_irq && $past(long_period))
      |-> $past(presc[`WT_FWX_LOG2-1:0]) == {`WT_FWX_LOG2{1'b1}})
      else $error("long period tick off the 2^9 tap");

   // RULE_09 ticks after the first are one period apart
   logic [15:0]                   tb_gap;
   logic                          gap_valid;
   watch_timer_pkg::tick_period_e gap_period;
   logic [15:0]                   gap_expect;

   always_comb begin
      gap_expect = 16'h0000;
      case (mode.tick_period)
         watch_timer_pkg::PERIOD_2P14: gap_expect = 16'((1 << `WT_PERIOD_2P14_LOG2) - 1);
         watch_timer_pkg::PERIOD_2P13: gap_expect = 16'((1 << `WT_PERIOD_2P13_LOG2) - 1);
         watch_timer_pkg::PERIOD_2P5:  gap_expect = 16'((1 << `WT_PERIOD_2P5_LOG2) - 1);
         watch_timer_pkg::PERIOD_2P4:  gap_expect = 16'((1 << `WT_PERIOD_2P4_LOG2) - 1);
         default:                      gap_expect = 16'h0000;
      endcase
   end

   // a period change restarts the spacing check, since the first tick may come early
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         gap_period <= watch_timer_pkg::PERIOD_2P14;
      end else begin
         gap_period <= mode.tick_period;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n || !watch_run || (mode.tick_period != gap_period)) begin
         tb_gap    <= 16'h0000;
         gap_valid <= 1'b0;
      end else if (watch_fire) begin
         tb_gap    <= 16'h0000;
         gap_valid <= 1'b1;
      end else if (tb_tick) begin
         tb_gap <= tb_gap + 16'h0001;
      end
   end

   chk_tick_spacing: assert property ( // RULE_09
      @(posedge clock) disable iff (!reset_n)
      (watch_fire && gap_valid) |-> (tb_gap == gap_expect))
      else $error("watch tick not one period after the last");

endmodule : watch_and_interval_timer

// ---- rtl/watch_counter.sv ----
`timescale 1ns/1ps
`include "watch_timer_defs.svh"

module watch_counter #(
   parameter int WIDTH = `WT_COUNT_WIDTH
) (
   input  wire logic             clock,
   input  wire logic             reset_n,
   input  wire logic             clear,
   input  wire logic             step,
   input  wire logic             half_span,
   output logic [WIDTH-1:0]      count,
   output logic                  overflow
);

   logic [WIDTH-1:0] top;

   initial begin
      if (WIDTH < 2) begin
         $error("watch counter needs at least two bits");
      end
   end

   // half span wraps one bit early, halving the period
   assign top      = half_span ? {1'b0, {(WIDTH-1){1'b1}}} : {WIDTH{1'b1}};
   assign overflow = step && !clear && (count == top);

   always_ff @(posedge clock) begin
      if (!reset_n || clear) begin
         count <= '0;
      end else if (overflow) begin
         count <= '0;
      end else if (step) begin
         count <= count + 1'b1;
      end
   end

endmodule : watch_counter

// ---- rtl/watch_timer_defs.svh ----
`ifndef WATCH_TIMER_DEFS_SVH
`define WATCH_TIMER_DEFS_SVH

// ==========================================================================
// register map
// ==========================================================================
`define WT_MODE_ADDR        16'hff6f
`define WT_MODE_RESET       8'h00

// ==========================================================================
// timebase and prescaler figures (bit widths, or log2 of clock or timebase cycles)
// ==========================================================================
`define WT_MAIN_DIV_LOG2    7
`define WT_PRESC_WIDTH      11
`define WT_COUNT_WIDTH      5
`define WT_FWX_LOG2         9
`define WT_INTERVAL_LOG2    4

// ==========================================================================
// watch tick periods (log2 of timebase cycles), by period code
// ==========================================================================
`define WT_PERIOD_2P14_LOG2 14
`define WT_PERIOD_2P13_LOG2 13
`define WT_PERIOD_2P5_LOG2  5
`define WT_PERIOD_2P4_LOG2  4

`endif

// ---- rtl/watch_timer_pkg.sv ----
package watch_timer_pkg;

   // ======================================================================
   // watch tick period field encodings, in register order
   // ======================================================================
   typedef enum logic [1:0] {
      PERIOD_2P14,
      PERIOD_2P13,
      PERIOD_2P5,
      PERIOD_2P4
   } tick_period_e;

   // ======================================================================
   // mode register layout, msb first
   // ======================================================================
   typedef struct packed {
      logic         timebase_select;
      logic [2:0]   interval_tap;
      tick_period_e tick_period;
      logic         counter_run;
      logic         global_enable;
   } mode_s;

   // ======================================================================
   // processor access to the mode register
   // ======================================================================
   typedef struct packed {
      logic [15:0] addr;
      logic        wr_byte;
      logic        wr_bit;
      logic [2:0]  bit_sel;
      logic        bit_val;
      logic [7:0]  wdata;
      logic        rd;
   } reg_req_s;

endpackage : watch_timer_pkg

// ---- sim/watch_and_interval_timer_test.sv ----
`timescale 1ns/1ps

module watch_and_interval_timer_test;

   // ======================================================================
   // clock, reset and stimulus
   // ======================================================================
   logic                      clock;
   logic                      reset_n;
   logic                      sub_osc_clk;
   watch_timer_pkg::reg_req_s reg_req;
   logic [7:0]                reg_rdata;
   logic                      watch_tick_irq;
   logic                      interval_tick_irq;
   int                        miscompares;
   int                        samples_checked;
   int                        wt_cnt;
   int                        it_cnt;
   int                        wt_base;
   int                        it_base;

   watch_and_interval_timer u_dut (
      .clock             (clock),
      .reset_n           (reset_n),
      .sub_osc_clk       (sub_osc_clk),
      .reg_req           (reg_req),
      .reg_rdata         (reg_rdata),
      .watch_tick_irq    (watch_tick_irq),
      .interval_tick_irq (interval_tick_irq)
   );

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // sampled 1 ns after the edge so the registered pulses have landed
   always @(posedge clock) begin
      #1;
      if (watch_tick_irq === 1'b1) wt_cnt++;
      if (interval_tick_irq === 1'b1) it_cnt++;
   end

   // ======================================================================
   // access and check tasks
   // ======================================================================
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_req.addr    = a;
      reg_req.wdata   = d;
      reg_req.wr_byte = 1'b1;
      @(negedge clock);
      reg_req.wr_byte = 1'b0;
   endtask : wr

   task automatic wr_bit(input logic [2:0] s, input logic v);
      @(negedge clock);
      reg_req.addr    = 16'hff6f;
      reg_req.bit_sel = s;
      reg_req.bit_val = v;
      reg_req.wr_bit  = 1'b1;
      @(negedge clock);
      reg_req.wr_bit  = 1'b0;
   endtask : wr_bit

   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
      @(negedge clock);
      reg_req.addr = a;
      reg_req.rd   = 1'b1;
      @(negedge clock);
      reg_req.rd   = 1'b0;
      check({8'h00, reg_rdata}, {8'h00, e});
   endtask : rd_chk

   // one timebase cycle per rising edge, two system clocks each
   task automatic sub_ticks(input int n);
      repeat (n) begin
         @(negedge clock);
         sub_osc_clk = 1'b1;
         @(negedge clock);
         sub_osc_clk = 1'b0;
      end
   endtask : sub_ticks

   task automatic mark();
      wt_base = wt_cnt;
      it_base = it_cnt;
   endtask : mark

   task automatic counts(input int w, input int i);
      repeat (3) @(negedge clock);
      check(16'(wt_cnt - wt_base), 16'(w));
      check(16'(it_cnt - it_base), 16'(i));
   endtask : counts

   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run

   // ======================================================================
   // tests
   // ======================================================================
   initial begin
      int per;
      reset_n         = 1'b0;
      sub_osc_clk     = 1'b0;
      reg_req         = '0;
      miscompares     = 0;
      samples_checked = 0;
      wt_cnt          = 0;
      it_cnt          = 0;
      repeat (6) @(negedge clock);
      reset_n = 1'b1;
      rd_chk(16'hff6f, 8'h00);
      // every tap code, run bit left low, subsystem timebase
      for (int t = 0; t < 8; t++) begin
         wr_bit(3'h0, 1'b0);
         wr(16'hff6f, 8'h80 | 8'(t << 4));
         mark();
         wr_bit(3'h0, 1'b1);
         rd_chk(16'hff6f, 8'h81 | 8'(t << 4));
         sub_ticks(2 << (4 + t));
         counts(0, 2);
      end
      // short watch periods, then run bit cleared alone
      for (int p = 3; p >= 2; p--) begin
         per = 1 << (7 - p);
         wr_bit(3'h0, 1'b0);
         wr(16'hff6f, 8'h81 | 8'(p << 2));
         mark();
         wr_bit(3'h1, 1'b1);
         sub_ticks(4 * per);
         counts(4, per / 4);
         wr_bit(3'h1, 1'b0);
         mark();
         sub_ticks(64);
         counts(0, 4);
      end
      // long period: first tick may come up to 2^9 - 1 early, never late, the next is exact
      wr_bit(3'h0, 1'b0);
      wr(16'hff6f, 8'h87);
      mark();
      sub_ticks(16896);
      counts(2, 1056);
      // longest period: exactly one tick within period plus the allowed lag
      wr_bit(3'h0, 1'b0);
      wr(16'hff6f, 8'h83);
      mark();
      sub_ticks(16896);
      counts(1, 1056);
      // main timebase, divider phase unknown so allow one tick of slack
      wr_bit(3'h0, 1'b0);
      wr(16'hff6f, 8'h01);
      mark();
      repeat (2 * 2048 + 130) @(negedge clock);
      counts(0, 2);
      // unmapped address ignored and read as zero
      wr(16'hff70, 8'hff);
      rd_chk(16'hff6f, 8'h01);
      rd_chk(16'hff70, 8'h00);
      wr_bit(3'h0, 1'b0);
      rd_chk(16'hff6f, 8'h00);
      complete_run();
   end

   // whole sequence needs about 8.9 ms of simulated time
   initial begin
      #9_500_000;
      miscompares++;
      complete_run();
   end

endmodule : watch_and_interval_timer_test
